// >>> shared/vpsc_pkg.sv
package vpsc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] PORT_PERIPHERAL_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] PORT_STATUS_ADDR = 8'h04;
  localparam logic [7:0] BLOCK_CONTROL_ADDR = 8'h08;
  localparam int PORT_ENABLE_BIT_POS = 2;
  localparam int GRACEFUL_HALT_POS = 1;
  localparam int RUN_THROUGH_HALT_POS = 0;
  localparam int CAPTURE_BLOCK_POS = 0;
  localparam int DISPLAY_BLOCK_POS = 1;
  localparam logic PORT_ENABLE_RESET = 1'b0;
  localparam logic RUN_THROUGH_HALT_RESET = 1'b0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [31:0] DISABLED_READ_FILL = 32'hdead_beef;
  localparam logic [9:0] DEFAULT_VIDEO_DATA = 10'h010;
  // ----------------------------------------
  // halt sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {
    HALT_RUN,
    HALT_DRAIN,
    HALT_STOPPED,
    HALT_RESUME
  } vpsc_halt_e;
endpackage

// >>> logic/vpsc_ctrl.sv
// Contract
// - upper control bits 31..3 read zero, writes to them ignored
// - port enable clear gates off both video clocks and stream clock
// - disabled port still acknowledges DMA; reads undefined, writes dropped
// - port enable set runs port with clocks ungated
// - graceful-halt select bit always reads zero
// - run-through-halt set ignores suspend; graceful select has no effect
// - run-through-halt clear finishes current field, then stops DMA events
// - clocks and timing counters keep running during suspend
// - no interrupts raised while halted by suspend
// - display mode under suspend keeps controls, drives default data in window
// - after suspend waits for field boundary before re-enabling DMA events
// - block controls act at once; software resets DMA before clearing
// - no separate capture-side suspend handling
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module vpsc_ctrl
  import vpsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // dma access port
  input wire logic dmaRead,
  input wire logic dmaWrite,
  input wire logic [31:0] dmaWdata,
  output logic dmaAck,
  output logic [31:0] dmaRdata,
  output logic dmaWriteAccept,
  // port core signals
  input wire logic emuSuspendReq,
  input wire logic fieldBoundary,
  input wire logic displayMode,
  input wire logic activeWindow,
  input wire logic coreIrqReq,
  input wire logic coreDmaEvent,
  input wire logic [31:0] fifoRdata,
  // gating and outputs
  output logic videoClockAEn,
  output logic videoClockBEn,
  output logic streamClockEn,
  output logic countersRun,
  output logic dmaEventOut,
  output logic portIrq,
  output logic defaultDataSel,
  output logic [9:0] videoDataOverride,
  output logic captureBlocked,
  output logic displayBlocked,
  output logic suspendHalted
);
  import vpsc_pkg::*;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic portEnable;
  logic runThroughHalt;
  logic captureBlock;
  logic displayBlock;
  logic suspMeta;
  logic suspSync;
  vpsc_halt_e haltState;
  vpsc_halt_e next_haltState;

  wire pcrSel = regAddr == PORT_PERIPHERAL_CONTROL_ADDR;
  wire statSel = regAddr == PORT_STATUS_ADDR;
  wire blkSel = regAddr == BLOCK_CONTROL_ADDR;
  wire pcrWr = regWrite && pcrSel;
  wire blkWr = regWrite && blkSel;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      portEnable <= PORT_ENABLE_RESET;
      runThroughHalt <= RUN_THROUGH_HALT_RESET;
    end
    else if (pcrWr)
    begin
      // only bits 2 and 0 store; 1 and 31..3 are dropped
      portEnable <= regWdata[PORT_ENABLE_BIT_POS];
      runThroughHalt <= regWdata[RUN_THROUGH_HALT_POS];
    end
  end

  // block bits take effect the next cycle, not at field end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      captureBlock <= 1'b0;
      displayBlock <= 1'b0;
    end
    else if (blkWr)
    begin
      captureBlock <= regWdata[CAPTURE_BLOCK_POS];
      displayBlock <= regWdata[DISPLAY_BLOCK_POS];
    end
  end

  // ----------------------------------------
  // suspend synchronizer and halt sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      suspMeta <= 1'b0;
      suspSync <= 1'b0;
    end
    else
    begin
      suspMeta <= emuSuspendReq;
      suspSync <= suspMeta;
    end
  end

  // run-through wins over any pending halt; one halt covers both paths
  wire suspEff = suspSync && !runThroughHalt;

  always_comb
  begin
    next_haltState = haltState;
    case (haltState)
      HALT_RUN:
        if (suspEff)
          next_haltState = HALT_DRAIN;
      HALT_DRAIN:
        if (!suspEff)
          next_haltState = HALT_RUN;
        else if (fieldBoundary)
          next_haltState = HALT_STOPPED;
      HALT_STOPPED:
        if (!suspEff)
          next_haltState = HALT_RESUME;
      HALT_RESUME:
        if (suspEff)
          next_haltState = HALT_STOPPED;
        else if (fieldBoundary)
          next_haltState = HALT_RUN;
      default:
        next_haltState = HALT_RUN;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      haltState <= HALT_RUN;
    else
      haltState <= next_haltState;
  end

  // ----------------------------------------
  // gating decode
  // ----------------------------------------
  wire halted = haltState == HALT_STOPPED || haltState == HALT_RESUME;
  wire eventsOk = portEnable && !halted && !captureBlock && !displayBlock;
  wire irqOk = portEnable && !halted;
  // default data only while halted (stopped or resuming) in display mode inside the window
  wire dfltSel = portEnable && halted && displayMode && activeWindow;
  wire [31:0] rdMux = pcrSel ? {29'h0, portEnable, 1'b0, runThroughHalt}
                    : statSel ? {29'h0, halted, suspSync, portEnable}
                    : blkSel ? {30'h0, displayBlock, captureBlock}
                    : READ_ZERO;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      regRdata <= READ_ZERO;
      videoClockAEn <= 1'b0;
      videoClockBEn <= 1'b0;
      streamClockEn <= 1'b0;
      countersRun <= 1'b0;
      dmaEventOut <= 1'b0;
      portIrq <= 1'b0;
      defaultDataSel <= 1'b0;
      videoDataOverride <= 10'h000;
      captureBlocked <= 1'b0;
      displayBlocked <= 1'b0;
      suspendHalted <= 1'b0;
    end
    else
    begin
      regRdata <= regRead ? rdMux : READ_ZERO;
      // clocks follow enable only; suspend never stops them
      videoClockAEn <= portEnable;
      videoClockBEn <= portEnable;
      streamClockEn <= portEnable;
      countersRun <= portEnable;
      dmaEventOut <= eventsOk && coreDmaEvent;
      portIrq <= irqOk && coreIrqReq;
      defaultDataSel <= dfltSel;
      videoDataOverride <= dfltSel ? DEFAULT_VIDEO_DATA : 10'h000;
      captureBlocked <= captureBlock;
      displayBlocked <= displayBlock;
      suspendHalted <= halted;
    end
  end

  // ----------------------------------------
  // dma slave: always acknowledged
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dmaAck <= 1'b0;
      dmaRdata <= READ_ZERO;
      dmaWriteAccept <= 1'b0;
    end
    else
    begin
      dmaAck <= dmaRead || dmaWrite;
      // disabled reads give a fill pattern, treated as undefined
      dmaRdata <= portEnable ? fifoRdata : DISABLED_READ_FILL;
      dmaWriteAccept <= dmaWrite && portEnable;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PCR_READ_MASK: assert property (@(posedge core_clk) disable iff (!rst_n)
    regRead && pcrSel |=> regRdata[31:3] == 29'h0)
    else $error("control upper bits not zero");
  AST_SOFT_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    regRead && pcrSel |=> !regRdata[GRACEFUL_HALT_POS])
    else $error("graceful bit read nonzero");
  AST_CLK_GATED: assert property (@(posedge core_clk) disable iff (!rst_n)
    pcrWr && !regWdata[PORT_ENABLE_BIT_POS] |=> ##1 !videoClockAEn && !streamClockEn)
    else $error("clocks not gated");
  AST_CLK_RUN: assert property (@(posedge core_clk) disable iff (!rst_n)
    pcrWr && regWdata[PORT_ENABLE_BIT_POS] |=> ##1 videoClockBEn && countersRun)
    else $error("clocks not running");
  AST_DMA_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
    dmaWrite && !portEnable |=> dmaAck && !dmaWriteAccept)
    else $error("disabled dma handling wrong");
  AST_FREE_IGNORE: assert property (@(posedge core_clk) disable iff (!rst_n)
    runThroughHalt && haltState == HALT_RUN |=> haltState == HALT_RUN)
    else $error("run-through halted");
  AST_HALT_AT_FIELD: assert property (@(posedge core_clk) disable iff (!rst_n)
    haltState == HALT_DRAIN && suspEff && fieldBoundary |=> ##1 !dmaEventOut)
    else $error("events after field end");
  AST_NO_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
    halted |=> !portIrq)
    else $error("irq while halted");
  AST_RESUME_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    haltState == HALT_RESUME && !fieldBoundary |=> !dmaEventOut)
    else $error("resumed before field boundary");
  AST_CLK_SUSP: assert property (@(posedge core_clk) disable iff (!rst_n)
    halted && $stable(portEnable) && portEnable |=> videoClockAEn)
    else $error("clock stopped in suspend");
  AST_DFLT: assert property (@(posedge core_clk) disable iff (!rst_n)
    dfltSel |=> videoDataOverride == DEFAULT_VIDEO_DATA)
    else $error("default data missing");
  AST_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
    blkWr && regWdata[CAPTURE_BLOCK_POS] |=> ##1 !dmaEventOut)
    else $error("block not immediate");
  AST_BLOCK_DISP: assert property (@(posedge core_clk) disable iff (!rst_n)
    blkWr && regWdata[DISPLAY_BLOCK_POS] |=> ##1 !dmaEventOut)
    else $error("display block not immediate");
  AST_DMA_RD_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
    dmaRead |=> dmaAck)
    else $error("dma read not acknowledged");
  AST_DMA_WR_DROP: assert property (@(posedge core_clk) disable iff (!rst_n)
    !portEnable |=> !dmaWriteAccept)
    else $error("write taken while disabled");
  AST_DIS_FILL: assert property (@(posedge core_clk) disable iff (!rst_n)
    !portEnable |=> dmaRdata == DISABLED_READ_FILL)
    else $error("disabled read not filled");
  AST_CLK_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    !portEnable |=> !videoClockAEn && !videoClockBEn && !streamClockEn)
    else $error("clock running while disabled");
  AST_CLK_ON: assert property (@(posedge core_clk) disable iff (!rst_n)
    portEnable |=> videoClockAEn && videoClockBEn && streamClockEn)
    else $error("clock gated while enabled");
  AST_CNT_SUSP: assert property (@(posedge core_clk) disable iff (!rst_n)
    halted && portEnable |=> countersRun && streamClockEn)
    else $error("counters stopped in suspend");
  AST_FREE_NO_HALT: assert property (@(posedge core_clk) disable iff (!rst_n)
    runThroughHalt && !halted |=> !halted)
    else $error("halted in run-through");
  AST_SUSP_SYNC: assert property (@(posedge core_clk) disable iff (!rst_n)
    haltState == HALT_RUN && !suspSync |=> haltState == HALT_RUN)
    else $error("halt from unsynced request");
  AST_DRAIN_PASS: assert property (@(posedge core_clk) disable iff (!rst_n)
    haltState == HALT_DRAIN && eventsOk && coreDmaEvent |=> dmaEventOut)
    else $error("events cut before field end");
  AST_RESUME_EDGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    haltState == HALT_RESUME && !suspEff && fieldBoundary |=> haltState == HALT_RUN)
    else $error("no resume at field boundary");
  AST_DFLT_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    !dfltSel |=> !defaultDataSel && videoDataOverride == 10'h000)
    else $error("default data outside window");

  COV_HALT: cover property (@(posedge core_clk) haltState == HALT_STOPPED);
  COV_RESUME: cover property (@(posedge core_clk)
    haltState == HALT_RESUME ##1 haltState == HALT_RUN);
  COV_DISABLED_DMA: cover property (@(posedge core_clk) dmaRead && !portEnable);
  COV_DEFAULT: cover property (@(posedge core_clk) defaultDataSel);
endmodule
`default_nettype wire

// >>> verification/vpsc_emu_model.sv
`timescale 1ns/100ps
`default_nettype none
module vpsc_emu_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // debugger halt
  input wire logic holdReq,
  // toward the port
  output logic emuSuspendReq
);
  // ----------------
  // suspend request
  // ----------------
  // launched off the falling edge so the port's synchronizer sees a foreign phase
  always_ff @(negedge core_clk)
  begin
    if (!rst_n)
      emuSuspendReq <= 1'b0;
    else
      emuSuspendReq <= holdReq;
  end
endmodule
`default_nettype wire

// >>> verification/vpsc_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module vpsc_ctrl_bench;
  import vpsc_pkg::*;
  logic core_clk, rst_n, regWrite, regRead, dmaRead, dmaWrite, holdReq, emuSuspendReq;
  logic fieldBoundary, displayMode, activeWindow, coreIrqReq, coreDmaEvent;
  logic dmaAck, dmaWriteAccept, videoClockAEn, videoClockBEn, streamClockEn, countersRun;
  logic dmaEventOut, portIrq, defaultDataSel, captureBlocked, displayBlocked, suspendHalted;
  logic [7:0] regAddr;
  logic [9:0] videoDataOverride;
  logic [31:0] regWdata, regRdata, dmaWdata, dmaRdata, fifoRdata, rdv, w;
  int miscompares, checksDone;
  vpsc_ctrl DUT (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .dmaRead(dmaRead),
    .dmaWrite(dmaWrite), .dmaWdata(dmaWdata), .dmaAck(dmaAck), .dmaRdata(dmaRdata),
    .dmaWriteAccept(dmaWriteAccept), .emuSuspendReq(emuSuspendReq),
    .fieldBoundary(fieldBoundary), .displayMode(displayMode), .activeWindow(activeWindow),
    .coreIrqReq(coreIrqReq), .coreDmaEvent(coreDmaEvent), .fifoRdata(fifoRdata),
    .videoClockAEn(videoClockAEn), .videoClockBEn(videoClockBEn),
    .streamClockEn(streamClockEn), .countersRun(countersRun), .dmaEventOut(dmaEventOut),
    .portIrq(portIrq), .defaultDataSel(defaultDataSel),
    .videoDataOverride(videoDataOverride), .captureBlocked(captureBlocked),
    .displayBlocked(displayBlocked), .suspendHalted(suspendHalted));
  vpsc_emu_model emu (.core_clk(core_clk), .rst_n(rst_n), .holdReq(holdReq),
    .emuSuspendReq(emuSuspendReq));
  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] expCtrl(input logic [31:0] d);
    return {29'h0, d[PORT_ENABLE_BIT_POS], 1'b0, d[RUN_THROUGH_HALT_POS]};
  endfunction
  function automatic logic [31:0] expClk(input logic [31:0] d);
    return {29'h0, {3{d[PORT_ENABLE_BIT_POS]}}};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic dma(input logic wrNotRd);
    @(posedge core_clk);
    {dmaWrite, dmaRead} <= {wrNotRd, !wrNotRd};
    dmaWdata <= $urandom;
    @(posedge core_clk);
    {dmaWrite, dmaRead} <= 2'b00;
    #1;
  endtask
  task automatic field;
    @(posedge core_clk);
    fieldBoundary <= 1'b1;
    @(posedge core_clk);
    fieldBoundary <= 1'b0;
    tick(3);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------
  // clock and watchdog
  // ----------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #500us;
    miscompares++;
    stop_test;
  end
  // ----------------
  // tests
  // ----------------
  initial
  begin
    void'($urandom(32'h451381be));
    {rst_n, regWrite, regRead, dmaRead, dmaWrite, holdReq, fieldBoundary} = '0;
    {displayMode, activeWindow, coreIrqReq, coreDmaEvent, regAddr} = '0;
    {regWdata, dmaWdata, fifoRdata} = '0;
    tick(8);
    rst_n <= 1'b1;
    rd(PORT_PERIPHERAL_CONTROL_ADDR, rdv);
    chk(rdv, READ_ZERO);
    chk({28'h0, videoClockAEn, videoClockBEn, streamClockEn, countersRun}, 32'h0);
    rd(8'hfc, rdv);
    chk(rdv, READ_ZERO);
    $display("test reset done");
    for (int i = 0; i < 20; i++)
    begin
      w = (i == 0) ? 32'hffff_fffb : $urandom;
      wr(PORT_PERIPHERAL_CONTROL_ADDR, w);
      rd(PORT_PERIPHERAL_CONTROL_ADDR, rdv);
      chk(rdv, expCtrl(w));
      chk({29'h0, videoClockAEn, videoClockBEn, streamClockEn}, expClk(w));
    end
    $display("test control done");
    for (int e = 0; e < 2; e++)
    begin
      wr(PORT_PERIPHERAL_CONTROL_ADDR, {29'h0, e[0], 2'b00});
      fifoRdata <= $urandom;
      dma(1'b0);
      chk({31'h0, dmaAck}, 32'h1);
      chk(dmaRdata, (e != 0) ? fifoRdata : DISABLED_READ_FILL);
      dma(1'b1);
      chk({30'h0, dmaAck, dmaWriteAccept}, {30'h0, 1'b1, e[0]});
    end
    $display("test dma done");
    wr(PORT_PERIPHERAL_CONTROL_ADDR, 32'h4);
    {displayMode, activeWindow, coreIrqReq} <= 3'b111;
    coreDmaEvent <= 1'b1;
    holdReq <= 1'b1;
    tick(6);
    #1;
    chk({30'h0, dmaEventOut, suspendHalted}, 32'h2);
    field;
    chk({29'h0, dmaEventOut, portIrq, suspendHalted}, 32'h1);
    chk({28'h0, videoClockAEn, videoClockBEn, streamClockEn, countersRun}, 32'hf);
    chk({21'h0, defaultDataSel, videoDataOverride}, {21'h0, 1'b1, DEFAULT_VIDEO_DATA});
    @(posedge core_clk) activeWindow <= 1'b0;
    tick(2);
    #1;
    chk({21'h0, defaultDataSel, videoDataOverride}, 32'h0);
    rd(PORT_STATUS_ADDR, rdv);
    chk(rdv, 32'h7);
    @(posedge core_clk) holdReq <= 1'b0;
    tick(6);
    #1;
    chk({31'h0, dmaEventOut}, 32'h0);
    field;
    chk({30'h0, dmaEventOut, portIrq}, 32'h3);
    $display("test suspend done");
    wr(PORT_PERIPHERAL_CONTROL_ADDR, 32'h7);
    @(posedge core_clk) holdReq <= 1'b1;
    tick(6);
    field;
    chk({30'h0, dmaEventOut, suspendHalted}, 32'h2);
    @(posedge core_clk) holdReq <= 1'b0;
    $display("test run through done");
    for (int b = 1; b < 4; b++)
    begin
      wr(BLOCK_CONTROL_ADDR, (b == 3) ? 32'h0 : b);
      tick(2);
      #1;
      chk({29'h0, captureBlocked, displayBlocked, dmaEventOut},
        (b == 3) ? 32'h1 : {29'h0, b[0], b[1], 1'b0});
    end
    $display("test block done");
    @(posedge core_clk) rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    rd(PORT_PERIPHERAL_CONTROL_ADDR, rdv);
    chk(rdv, READ_ZERO);
    chk({27'h0, videoClockAEn, videoClockBEn, streamClockEn, countersRun, dmaEventOut}, 32'h0);
    $display("test reset again done");
    stop_test;
  end
endmodule
`default_nettype wire
